//--- rtl/cmx_exec.sv
// execute stage for or/move/literal/option/return/nop/sleep instructions
`include "cmx_params.svh"
`default_nettype none
module cmx_exec #(
    parameter int PC_W = 11
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // instruction stream
    input  wire logic [11:0]     instr,
    input  wire logic            instr_valid,
    input  wire logic [PC_W-1:0] stack_top,
    // file register read port
    output logic [4:0]           file_raddr,
    input  wire logic [7:0]      file_rdata,
    // file register write port
    output cmx_pkg::cmx_fwr_t    file_wr,
    // core state
    output logic [7:0]           w_out,
    output logic [7:0]           option_out,
    output logic [PC_W-1:0]      pc_out,
    output cmx_pkg::cmx_flags_t  flags_out,
    input  wire logic            pin_wake_flag,
    output logic                 pin_wake_out,
    // power management
    output logic                 watchdog_clear,
    output logic                 osc_halt,
    input  wire logic            wake
);
    import cmx_pkg::*;

    // counter widths outside this range are refused at elaboration
    if (PC_W < 9 || PC_W > 16)
    begin : g_pc_w_check
        $error("cmx_exec: PC_W out of range");
    end

    cmx_state_t          state_reg, state_next;
    logic [7:0]          w_reg;
    logic [7:0]          opt_reg;
    logic [PC_W-1:0]     pc_reg;
    cmx_flags_t          flg_reg;
    cmx_fwr_t            fwr_reg;
    logic                wdc_reg;

    function automatic logic is_op(input logic [11:0] i, input logic [11:0] m, input logic [11:0] v);
        return (i & m) == v;
    endfunction

    wire       run         = (state_reg == CMX_RUN) && instr_valid;
    wire       op_or_file  = run && is_op(instr, `CMX_MSK_BYTE, `CMX_VAL_OR_FILE);
    wire       op_copy     = run && is_op(instr, `CMX_MSK_BYTE, `CMX_VAL_COPY);
    wire       op_store    = run && is_op(instr, `CMX_MSK_STORE, `CMX_VAL_STORE);
    wire       op_load_lit = run && is_op(instr, `CMX_MSK_LIT, `CMX_VAL_LOAD_LIT);
    wire       op_return   = run && is_op(instr, `CMX_MSK_LIT, `CMX_VAL_RETURN);
    wire       op_option   = run && (instr == `CMX_OP_OPTION);
    wire       op_sleep    = run && (instr == `CMX_OP_SLEEP);
    wire       op_nop      = run && (instr == `CMX_OP_NOP);
    wire [4:0] f_addr      = instr[4:0];
    wire       dest_f      = instr[`CMX_D_BIT];
    wire [7:0] literal     = instr[7:0];
    wire [7:0] or_res      = w_reg | file_rdata;
    wire [7:0] alu_res     = op_or_file ? or_res : file_rdata;
    wire       alu_op      = op_or_file || op_copy;
    wire [7:0] w_next      = (alu_op && !dest_f) ? alu_res :
                             (op_load_lit || op_return) ? literal : w_reg;
    // sleep and return never step the counter; return loads it instead
    wire       pc_step     = run && !op_sleep && !op_return;

    assign file_raddr = f_addr;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CMX_RUN:
            begin
                if (op_return)
                    state_next = CMX_FLUSH;
                else if (op_sleep)
                    state_next = CMX_SLEEP;
            end
            CMX_FLUSH: state_next = CMX_RUN;
            CMX_SLEEP:
            begin
                if (wake)
                    state_next = CMX_RUN;
            end
            default: state_next = CMX_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= CMX_RUN;
            w_reg     <= `CMX_W_RST;
            opt_reg   <= `CMX_OPT_RST;
            pc_reg    <= PC_W'(`CMX_PC_RST);
            flg_reg   <= `CMX_FLAGS_RST;
            fwr_reg   <= '0;
            wdc_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            w_reg     <= w_next;
            if (op_option)
                opt_reg <= w_reg;
            if (op_return)
                pc_reg <= stack_top;
            else if (pc_step)
                pc_reg <= pc_reg + 1'b1;
            if (alu_op)
                flg_reg.zero <= (alu_res == 8'h00);
            if (op_sleep)
            begin
                flg_reg.timeout   <= 1'b1;
                flg_reg.powerdown <= 1'b0;
            end
            // write-back is registered: the file sees it one cycle after execute
            fwr_reg.we   <= (alu_op && dest_f) || op_store;
            fwr_reg.addr <= f_addr;
            fwr_reg.data <= op_store ? w_reg : alu_res;
            wdc_reg      <= op_sleep;
        end
    end

    assign file_wr        = fwr_reg;
    assign w_out          = w_reg;
    assign option_out     = opt_reg;
    assign pc_out         = pc_reg;
    assign flags_out      = flg_reg;
    assign pin_wake_out   = pin_wake_flag;
    assign watchdog_clear = wdc_reg;
    assign osc_halt       = (state_reg == CMX_SLEEP);

    // assertions
    sequence s_sleep_taken;
        op_sleep;
    endsequence

    sequence s_return_taken;
        op_return;
    endsequence

    sequence s_flush_then_run;
        (state_reg == CMX_FLUSH) ##1 (state_reg == CMX_RUN);
    endsequence

    or_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        op_or_file |=> flg_reg.zero == ($past(or_res) == 8'h00))
        else $error("zero flag wrong after or");
    dest_w_a: assert property (@(posedge clk) disable iff (sys_rst)
        (op_or_file && !dest_f) |=> (w_reg == $past(or_res)) && !file_wr.we)
        else $error("or result not in W");
    or_file_a: assert property (@(posedge clk) disable iff (sys_rst)
        (op_or_file && dest_f) |=> file_wr.we && file_wr.addr == $past(f_addr)
            && file_wr.data == $past(or_res) && $stable(w_reg))
        else $error("or result not in file");
    store_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
        op_store |=> file_wr.we && file_wr.data == $past(w_reg) && $stable(flags_out))
        else $error("store to file wrong");
    copy_file_a: assert property (@(posedge clk) disable iff (sys_rst)
        (op_copy && dest_f) |=> file_wr.we && file_wr.data == $past(file_rdata) && $stable(w_reg)
            && flg_reg.zero == ($past(file_rdata) == 8'h00))
        else $error("copy file wrong");
    copy_w_a: assert property (@(posedge clk) disable iff (sys_rst)
        (op_copy && !dest_f) |=> w_reg == $past(file_rdata) && !file_wr.we
            && flg_reg.zero == ($past(file_rdata) == 8'h00))
        else $error("copy to W wrong");
    literal_w_a: assert property (@(posedge clk) disable iff (sys_rst)
        op_load_lit |=> w_reg == $past(literal) && $stable(flags_out))
        else $error("literal load wrong");
    zero_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(op_or_file || op_copy) |=> $stable(flg_reg.zero))
        else $error("zero flag changed by non-alu op");
    option_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        op_option |=> option_out == $past(w_reg) && $stable(flags_out))
        else $error("option load wrong");
    option_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        !op_option |=> $stable(option_out))
        else $error("option changed without load");
    return_pc_a: assert property (@(posedge clk) disable iff (sys_rst)
        op_return |=> pc_out == $past(stack_top) && w_reg == $past(literal))
        else $error("return wrong");
    return_two_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_return_taken |=> s_flush_then_run ##0 $stable(pc_out))
        else $error("return not two cycles");
    return_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_return_taken |=> $stable(flags_out) ##1 $stable(flags_out))
        else $error("return changed flags");
    flush_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == CMX_FLUSH && instr_valid) |=> $stable(w_reg) && $stable(pc_out) && !file_wr.we)
        else $error("instruction ran in flush cycle");
    sleep_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_sleep_taken |=> flg_reg.timeout && !flg_reg.powerdown)
        else $error("sleep flags wrong");
    sleep_wdog_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_sleep_taken |=> watchdog_clear ##1 !watchdog_clear)
        else $error("watchdog clear missing");
    sleep_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_sleep_taken ##1 !wake) |=> osc_halt)
        else $error("oscillator not halted");
    sleep_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
        (osc_halt && !wake) |=> osc_halt && $stable(w_reg) && $stable(pc_out) && !file_wr.we)
        else $error("core ran while halted");
    wake_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
        (osc_halt && wake) |=> !osc_halt)
        else $error("wake did not leave sleep");
    nop_only_a: assert property (@(posedge clk) disable iff (sys_rst)
        op_nop |=> pc_out == $past(pc_out) + 1'b1 && $stable(w_reg) && $stable(flags_out)
            && $stable(option_out) && !file_wr.we)
        else $error("nop changed state");
endmodule
`default_nettype wire

//--- common/cmx_params.svh
// constants for the move/or/sleep execute block
`ifndef CMX_PARAMS_SVH
`define CMX_PARAMS_SVH
`define CMX_OP_NOP      12'h000
`define CMX_OP_OPTION   12'h002
`define CMX_OP_SLEEP    12'h003
`define CMX_MSK_STORE    12'hFE0
`define CMX_VAL_STORE    12'h020
`define CMX_MSK_BYTE     12'hFC0
`define CMX_VAL_OR_FILE  12'h100
`define CMX_VAL_COPY     12'h200
`define CMX_MSK_LIT      12'hF00
`define CMX_VAL_RETURN   12'h800
`define CMX_VAL_LOAD_LIT 12'hC00
`define CMX_D_BIT        5
`define CMX_W_RST        8'h00
`define CMX_OPT_RST      8'hFF
`define CMX_PC_RST       11'h7FF
// timeout and powerdown set, zero clear
`define CMX_FLAGS_RST    3'b110
`endif

//--- common/cmx_pkg.sv
// types for the move/or/sleep execute block
`default_nettype none
package cmx_pkg;
    typedef enum logic [1:0]
    {
        CMX_RUN   = 2'b00,
        CMX_FLUSH = 2'b01,
        CMX_SLEEP = 2'b10
    } cmx_state_t;
    typedef struct packed
    {
        logic       we;
        logic [4:0] addr;
        logic [7:0] data;
    } cmx_fwr_t;
    typedef struct packed
    {
        logic timeout;
        logic powerdown;
        logic zero;
    } cmx_flags_t;
endpackage
`default_nettype wire

//--- dv/cmx_file_model.sv
// behavioural file register space facing the execute block
`default_nettype none
module cmx_file_model
(
    // clock
    input  wire logic              clk,
    // read and write ports
    input  wire logic [4:0]        raddr,
    output logic [7:0]             rdata,
    input  wire cmx_pkg::cmx_fwr_t wr
);
    timeunit 1ns;
    timeprecision 1ns;
    import cmx_pkg::*;
    logic [7:0] mem [32];
    // read answers in the same cycle
    assign rdata = mem[raddr];
    always @(posedge clk)
        if (wr.we)
            mem[wr.addr] <= wr.data;
endmodule
`default_nettype wire

//--- dv/cmx_exec_tb.sv
// self-checking bench for the execute block
`default_nettype none
module cmx_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cmx_pkg::*;
    logic        clk = 0, sys_rst = 1, instr_valid = 0, pin_wake_flag = 0, wake = 0;
    logic [11:0] instr = 0;
    logic [10:0] stack_top = 0, pc_out;
    logic [4:0]  file_raddr;
    logic [7:0]  file_rdata, w_out, option_out;
    logic        pin_wake_out, watchdog_clear, osc_halt;
    cmx_fwr_t    file_wr;
    cmx_flags_t  flags_out;
    int          bad_count = 0, comparisons = 0;
    always #20 clk = ~clk;
    cmx_exec dut (.clk(clk), .sys_rst(sys_rst), .instr(instr), .instr_valid(instr_valid),
        .stack_top(stack_top), .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr),
        .w_out(w_out), .option_out(option_out), .pc_out(pc_out), .flags_out(flags_out),
        .pin_wake_flag(pin_wake_flag), .pin_wake_out(pin_wake_out),
        .watchdog_clear(watchdog_clear), .osc_halt(osc_halt), .wake(wake));
    cmx_file_model u_files (.clk(clk), .raddr(file_raddr), .rdata(file_rdata), .wr(file_wr));
    task end_of_test();
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one instruction; returns in the cycle its results show
    task run(input logic [11:0] op);
        @(posedge clk);
        #1;
        instr = op;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
    endtask
    // two words back to back, valid held high between them
    task run2(input logic [11:0] op_a, input logic [11:0] op_b);
        @(posedge clk);
        #1;
        instr = op_a;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
        instr = op_b;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
    endtask
    initial
    begin
        #80000;
        bad_count++;
        end_of_test();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk("pc", 16'h07FF, pc_out);
        chk("flags", 16'h0006, flags_out);
        chk("w", 16'h0000, w_out);
        chk("option", 16'h00FF, option_out);
        run(12'hC00);
        run(12'h03F);
        run(12'h23F);
        chk("fwr", {2'b00, 1'b1, 5'd31, 8'h00}, file_wr);
        chk("flags", 16'h0007, flags_out);
        run(12'hCA5);
        chk("w", 16'h00A5, w_out);
        chk("flags", 16'h0007, flags_out);
        run(12'h023);
        chk("fwr", {2'b00, 1'b1, 5'd3, 8'hA5}, file_wr);
        chk("flags", 16'h0007, flags_out);
        run(12'hC00);
        run(12'h103);
        chk("w", 16'h00A5, w_out);
        chk("flags", 16'h0006, flags_out);
        chk("we", 16'h0000, file_wr.we);
        chk("raddr", 16'h0003, file_raddr);
        run(12'hC5A);
        run(12'h123);
        chk("fwr", {2'b00, 1'b1, 5'd3, 8'hFF}, file_wr);
        chk("w", 16'h005A, w_out);
        run(12'h21F);
        chk("w", 16'h0000, w_out);
        chk("flags", 16'h0007, flags_out);
        run(12'hC3C);
        run(12'h002);
        chk("option", 16'h003C, option_out);
        chk("flags", 16'h0007, flags_out);
        stack_top = 11'h155;
        // second word lands in the flush cycle and must be refused
        run2(12'h877, 12'hC11);
        chk("w", 16'h0077, w_out);
        chk("pc", 16'h0155, pc_out);
        chk("w", 16'h0077, w_out);
        chk("flags", 16'h0007, flags_out);
        run(12'h000);
        chk("pc", 16'h0156, pc_out);
        chk("state", 16'h773C, {w_out, option_out});
        chk("flags", 16'h0007, flags_out);
        pin_wake_flag = 1'b1;
        run(12'h003);
        chk("flags", 16'h0005, flags_out);
        chk("pinwake", 16'h0001, pin_wake_out);
        chk("wdclr", 16'h0001, watchdog_clear);
        chk("halt", 16'h0001, osc_halt);
        run(12'hC11);
        chk("w", 16'h0077, w_out);
        chk("wdclr", 16'h0000, watchdog_clear);
        wake = 1'b1;
        @(posedge clk);
        #1;
        wake = 1'b0;
        chk("halt", 16'h0000, osc_halt);
        end_of_test();
    end
endmodule
`default_nettype wire
